// [src/radio_cfg_pkg.sv]
// Constants, types and helpers for the radio configuration and wake timer registers
// Operation
// - Transmit start waits an 8-bit delay in 1 us steps, reset 192.
// - An 8-bit extension in 4 us steps lengthens both start delays, reset 0.
// - Format 0 is packet mode, 2 receive streaming, 3 transmit streaming; others reserved.
// - Channel word is 24 bits in 10 kHz units, low byte at lowest address.
// - Shaping bit 0 enables pre-emphasis, reset enabled; bits 7:1 belong to controller.
// - Receive power reads back as signed dBm byte, reset zero, read only.
// - Signal quality reads back as an 8-bit read-only value, reset zero.
// - Transmit frame store base is an 8-bit address, reset 128.
// - Receive frame store base is an 8-bit address, reset 0.
// - Divider codes 0 to 7 divide the slow clock by 1,4,8,16,128,1024,8192,65536.
// - Divider is write only and takes effect when sleep configuration is written.
// - Retention codes: 1 backup RAM, 4 crystal, 5 both, 11 RAM with RC.
// - Sleep configuration bit 0 enables wake on timer timeout, reset disabled.
// - Reload high byte is staged; writing the low byte commits the 16-bit value.
// - Receive start waits a delay, reset 192, before frame search and power window; the code only starts frame search (rx_search_start), with no power window.
package radio_cfg_pkg;

    // Clock and delay timing
    localparam int unsigned CLK_HZ       = 40_000_000;
    localparam int unsigned STEP_US      = 1;
    localparam int unsigned EXT_STEP_US  = 4;
    localparam int unsigned CYC_PER_US   = (CLK_HZ / 1_000_000 * STEP_US);
    localparam logic [5:0]  CYC_LAST     = 6'(CYC_PER_US - 1);

    // Register indices; byte address is four times the index
    localparam logic [11:0] IDX_RX_DELAY   = 12'h109;
    localparam logic [11:0] IDX_TX_DELAY   = 12'h10a;
    localparam logic [11:0] IDX_DELAY_EXT  = 12'h10b;
    localparam logic [11:0] IDX_PKT_FMT    = 12'h13e;
    localparam logic [11:0] IDX_CHAN_LO    = 12'h300;
    localparam logic [11:0] IDX_CHAN_MID   = 12'h301;
    localparam logic [11:0] IDX_CHAN_HI    = 12'h302;
    localparam logic [11:0] IDX_TX_SHAPE   = 12'h306;
    localparam logic [11:0] IDX_RX_POWER   = 12'h30c;
    localparam logic [11:0] IDX_RX_QUAL    = 12'h30d;
    localparam logic [11:0] IDX_PRAM_PAGE  = 12'h313;
    localparam logic [11:0] IDX_TX_BASE    = 12'h314;
    localparam logic [11:0] IDX_RX_BASE    = 12'h315;
    localparam logic [11:0] IDX_DIV_SEL    = 12'h316;
    localparam logic [11:0] IDX_SLEEP_CFG  = 12'h317;
    localparam logic [11:0] IDX_RELOAD_HI  = 12'h318;
    localparam logic [11:0] IDX_RELOAD_LO  = 12'h319;

    // Reset values
    localparam logic [7:0] RST_RX_DELAY  = 8'hc0;
    localparam logic [7:0] RST_TX_DELAY  = 8'hc0;
    localparam logic [7:0] RST_CHAN_LO   = 8'h80;
    localparam logic [7:0] RST_CHAN_MID  = 8'ha9;
    localparam logic [7:0] RST_CHAN_HI   = 8'h03;
    localparam logic [7:0] RST_TX_SHAPE  = 8'h01;
    localparam logic [7:0] RST_TX_BASE   = 8'h80;
    localparam logic [7:0] RST_ZERO      = 8'h00;

    // Field positions and codes
    localparam int unsigned PREEMP_BIT    = 0;
    localparam int unsigned WAKE_EN_BIT   = 0;
    localparam int unsigned RETAIN_LSB    = 3;
    localparam logic [7:0]  FMT_PACKET    = 8'h00;
    localparam logic [7:0]  FMT_STREAM_RX = 8'h02;
    localparam logic [7:0]  FMT_STREAM_TX = 8'h03;
    localparam logic [3:0]  SLP_RAM       = 4'h1;
    localparam logic [3:0]  SLP_XTAL      = 4'h4;
    localparam logic [3:0]  SLP_RAM_XTAL  = 4'h5;
    localparam logic [3:0]  SLP_RAM_RC    = 4'hb;

    typedef enum logic [1:0] {
        D_IDLE  = 2'b00,
        D_COUNT = 2'b01,
        D_FIRE  = 2'b11
    } dly_state_t;

    typedef struct packed {
        logic [23:0] channel_frequency_word;
        logic        preemphasis_en;
        logic [7:0]  packet_format_select;
        logic [3:0]  program_page;
        logic [7:0]  tx_frame_base;
        logic [7:0]  rx_frame_base;
    } radio_cfg_t;

    typedef struct packed {
        logic [7:0]  rx_delay, tx_delay, delay_ext, pkt_fmt;
        logic [7:0]  chan_lo, chan_mid, chan_hi, tx_shape;
        logic [7:0]  rx_power, rx_quality, tx_base, rx_base, sleep_cfg, reload_hi;
        logic [3:0]  pram_page;
        logic [2:0]  div_staged, div_active;
        logic [15:0] reload_active;
        dly_state_t  dly_st;
        logic        dly_is_tx;
        logic [5:0]  cyc_cnt;
        logic [10:0] us_cnt;
        logic [2:0]  slow_sync;
        logic [15:0] pre_cnt, wake_cnt;
        logic        wake_evt;
        logic        ack;
        logic [31:0] dat;
    } state_t;

    // Terminal prescaler count for each divider code
    function automatic logic [15:0] div_limit(input logic [2:0] code);
        case (code)
            3'd0:    div_limit = 16'h0000;
            3'd1:    div_limit = 16'h0003;
            3'd2:    div_limit = 16'h0007;
            3'd3:    div_limit = 16'h000f;
            3'd4:    div_limit = 16'h007f;
            3'd5:    div_limit = 16'h03ff;
            3'd6:    div_limit = 16'h1fff;
            default: div_limit = 16'hffff;
        endcase
    endfunction

    // Delay in microseconds: base in 1 us steps plus extension in 4 us steps
    function automatic logic [10:0] delay_us(input logic [7:0] base, input logic [7:0] ext);
        delay_us = {3'b000, base} + {1'b0, ext, 2'b00};
    endfunction

endpackage

// [src/radio_config_wake_timer_regs.sv]
// Radio configuration registers, start delay sequencer and wake timer
//
// Local design decision: the Wishbone register port.
`timescale 1ns/1ps
module radio_config_wake_timer_regs (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       reset,
    // Wishbone classic slave
    input  wire logic                       cyc_i,
    input  wire logic                       stb_i,
    input  wire logic                       we_i,
    input  wire logic [13:0]                adr_i,
    input  wire logic [3:0]                 sel_i,
    input  wire logic [31:0]                dat_i,
    output logic                            ack_o,
    output logic [31:0]                     dat_o,
    // Radio controller commands and measurements
    input  wire logic                       transmit_command,
    input  wire logic                       receive_command,
    input  wire logic                       rssi_valid,
    input  wire logic [7:0]                 rssi_in,
    input  wire logic                       sqi_valid,
    input  wire logic [7:0]                 sqi_in,
    output logic                            tx_state_enter,
    output logic                            rx_search_start,
    output logic                            start_delay_busy,
    // Configuration to the radio
    output radio_cfg_pkg::radio_cfg_t       radio_cfg,
    output logic                            packet_mode,
    output logic                            serial_stream_rx_en,
    output logic                            serial_stream_tx_en,
    output logic                            format_reserved,
    // Wake timer and sleep
    input  wire logic                       slow_clock_pin,
    output logic                            wake_event,
    output logic                            retain_backup_ram,
    output logic                            keep_crystal_running,
    output logic                            retain_rc_clock
);

    radio_cfg_pkg::state_t s_r;
    radio_cfg_pkg::state_t s_nxt;
    logic [11:0]           idx;
    logic                  take;
    logic                  wr;
    logic                  slow_edge;
    logic                  pre_tick;
    logic [7:0]            rd_byte;

    assign idx       = adr_i[13:2];
    assign take      = cyc_i && stb_i && !s_r.ack;
    assign wr        = take && we_i && sel_i[0];
    assign slow_edge = s_r.slow_sync[1] && !s_r.slow_sync[2];
    assign pre_tick  = slow_edge && (s_r.pre_cnt == radio_cfg_pkg::div_limit(s_r.div_active));

    ////////////////////////////////////////////////////////////////////////////////
    // Read multiplexer; write-only and unmapped locations read zero

    always_comb begin
        case (idx)
            radio_cfg_pkg::IDX_RX_DELAY:  rd_byte = s_r.rx_delay;
            radio_cfg_pkg::IDX_TX_DELAY:  rd_byte = s_r.tx_delay;
            radio_cfg_pkg::IDX_DELAY_EXT: rd_byte = s_r.delay_ext;
            radio_cfg_pkg::IDX_PKT_FMT:   rd_byte = s_r.pkt_fmt;
            radio_cfg_pkg::IDX_CHAN_LO:   rd_byte = s_r.chan_lo;
            radio_cfg_pkg::IDX_CHAN_MID:  rd_byte = s_r.chan_mid;
            radio_cfg_pkg::IDX_CHAN_HI:   rd_byte = s_r.chan_hi;
            radio_cfg_pkg::IDX_TX_SHAPE:  rd_byte = s_r.tx_shape;
            radio_cfg_pkg::IDX_RX_POWER:  rd_byte = s_r.rx_power;
            radio_cfg_pkg::IDX_RX_QUAL:   rd_byte = s_r.rx_quality;
            radio_cfg_pkg::IDX_PRAM_PAGE: rd_byte = {4'h0, s_r.pram_page};
            radio_cfg_pkg::IDX_TX_BASE:   rd_byte = s_r.tx_base;
            radio_cfg_pkg::IDX_RX_BASE:   rd_byte = s_r.rx_base;
            radio_cfg_pkg::IDX_SLEEP_CFG: rd_byte = s_r.sleep_cfg;
            radio_cfg_pkg::IDX_RELOAD_LO: rd_byte = s_r.reload_active[7:0];
            default:                      rd_byte = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        s_nxt = s_r;
        s_nxt.ack = take;
        s_nxt.wake_evt = 1'b0;
        if (take) begin
            s_nxt.dat = {24'h00_0000, rd_byte};
        end

        // Register writes; readback locations are absent so writes fall away
        if (wr) begin
            case (idx)
                radio_cfg_pkg::IDX_RX_DELAY:  s_nxt.rx_delay = dat_i[7:0];
                radio_cfg_pkg::IDX_TX_DELAY:  s_nxt.tx_delay = dat_i[7:0];
                radio_cfg_pkg::IDX_DELAY_EXT: s_nxt.delay_ext = dat_i[7:0];
                radio_cfg_pkg::IDX_PKT_FMT:   s_nxt.pkt_fmt = dat_i[7:0];
                radio_cfg_pkg::IDX_CHAN_LO:   s_nxt.chan_lo = dat_i[7:0];
                radio_cfg_pkg::IDX_CHAN_MID:  s_nxt.chan_mid = dat_i[7:0];
                radio_cfg_pkg::IDX_CHAN_HI:   s_nxt.chan_hi = dat_i[7:0];
                radio_cfg_pkg::IDX_TX_SHAPE:  s_nxt.tx_shape = dat_i[7:0];
                radio_cfg_pkg::IDX_PRAM_PAGE: s_nxt.pram_page = dat_i[3:0];
                radio_cfg_pkg::IDX_TX_BASE:   s_nxt.tx_base = dat_i[7:0];
                radio_cfg_pkg::IDX_RX_BASE:   s_nxt.rx_base = dat_i[7:0];
                radio_cfg_pkg::IDX_DIV_SEL:   s_nxt.div_staged = dat_i[2:0];
                radio_cfg_pkg::IDX_RELOAD_HI: s_nxt.reload_hi = dat_i[7:0];
                default: ;
            endcase
        end

        // Measurement capture
        if (rssi_valid) begin
            s_nxt.rx_power = rssi_in;
        end
        if (sqi_valid) begin
            s_nxt.rx_quality = sqi_in;
        end

        // Start delay sequencer
        case (s_r.dly_st)
            radio_cfg_pkg::D_IDLE: begin
                s_nxt.cyc_cnt = 6'd0;
                if (transmit_command) begin
                    s_nxt.dly_is_tx = 1'b1;
                    s_nxt.us_cnt = radio_cfg_pkg::delay_us(s_r.tx_delay, s_r.delay_ext);
                    s_nxt.dly_st = radio_cfg_pkg::D_COUNT;
                end else if (receive_command) begin
                    s_nxt.dly_is_tx = 1'b0;
                    s_nxt.us_cnt = radio_cfg_pkg::delay_us(s_r.rx_delay, s_r.delay_ext);
                    s_nxt.dly_st = radio_cfg_pkg::D_COUNT;
                end
            end
            radio_cfg_pkg::D_COUNT: begin
                if (s_r.us_cnt == 11'd0) begin
                    s_nxt.dly_st = radio_cfg_pkg::D_FIRE;
                end else if (s_r.cyc_cnt == radio_cfg_pkg::CYC_LAST) begin
                    s_nxt.cyc_cnt = 6'd0;
                    s_nxt.us_cnt = s_r.us_cnt - 11'd1;
                end else begin
                    s_nxt.cyc_cnt = s_r.cyc_cnt + 6'd1;
                end
            end
            radio_cfg_pkg::D_FIRE: s_nxt.dly_st = radio_cfg_pkg::D_IDLE;
            default:               s_nxt.dly_st = radio_cfg_pkg::D_IDLE;
        endcase

        // Wake timer: slow clock synchroniser, prescaler and reload counter
        s_nxt.slow_sync = {s_r.slow_sync[1:0], slow_clock_pin};
        if (!s_r.sleep_cfg[radio_cfg_pkg::WAKE_EN_BIT]) begin
            s_nxt.pre_cnt = 16'h0000;
            s_nxt.wake_cnt = s_r.reload_active;
        end else if (slow_edge) begin
            if (pre_tick) begin
                s_nxt.pre_cnt = 16'h0000;
                if (s_r.wake_cnt == 16'h0000) begin
                    s_nxt.wake_evt = 1'b1;
                    s_nxt.wake_cnt = s_r.reload_active;
                end else begin
                    s_nxt.wake_cnt = s_r.wake_cnt - 16'h0001;
                end
            end else begin
                s_nxt.pre_cnt = s_r.pre_cnt + 16'h0001;
            end
        end

        // Committing writes move staged timer settings into the running timer
        if (wr && idx == radio_cfg_pkg::IDX_SLEEP_CFG) begin
            s_nxt.sleep_cfg = dat_i[7:0];
            s_nxt.div_active = s_r.div_staged;
            s_nxt.pre_cnt = 16'h0000;
        end
        if (wr && idx == radio_cfg_pkg::IDX_RELOAD_LO) begin
            s_nxt.reload_active = {s_r.reload_hi, dat_i[7:0]};
            s_nxt.wake_cnt = {s_r.reload_hi, dat_i[7:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clk) begin
        if (reset) begin
            s_r <= '0;
            s_r.rx_delay <= radio_cfg_pkg::RST_RX_DELAY;
            s_r.tx_delay <= radio_cfg_pkg::RST_TX_DELAY;
            s_r.delay_ext <= radio_cfg_pkg::RST_ZERO;
            s_r.chan_lo <= radio_cfg_pkg::RST_CHAN_LO;
            s_r.chan_mid <= radio_cfg_pkg::RST_CHAN_MID;
            s_r.chan_hi <= radio_cfg_pkg::RST_CHAN_HI;
            s_r.tx_shape <= radio_cfg_pkg::RST_TX_SHAPE;
            s_r.tx_base <= radio_cfg_pkg::RST_TX_BASE;
            s_r.rx_base <= radio_cfg_pkg::RST_ZERO;
            s_r.dly_st <= radio_cfg_pkg::D_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign ack_o            = s_r.ack;
    assign dat_o            = s_r.dat;
    assign tx_state_enter   = (s_r.dly_st == radio_cfg_pkg::D_FIRE) && s_r.dly_is_tx;
    assign rx_search_start  = (s_r.dly_st == radio_cfg_pkg::D_FIRE) && !s_r.dly_is_tx;
    assign start_delay_busy = (s_r.dly_st != radio_cfg_pkg::D_IDLE);
    assign wake_event       = s_r.wake_evt;

    assign radio_cfg.channel_frequency_word = {s_r.chan_hi, s_r.chan_mid, s_r.chan_lo};
    assign radio_cfg.preemphasis_en         = s_r.tx_shape[radio_cfg_pkg::PREEMP_BIT];
    assign radio_cfg.packet_format_select   = s_r.pkt_fmt;
    assign radio_cfg.program_page           = s_r.pram_page;
    assign radio_cfg.tx_frame_base          = s_r.tx_base;
    assign radio_cfg.rx_frame_base          = s_r.rx_base;

    // Reserved format codes select no mode at all
    assign packet_mode         = (s_r.pkt_fmt == radio_cfg_pkg::FMT_PACKET);
    assign serial_stream_rx_en = (s_r.pkt_fmt == radio_cfg_pkg::FMT_STREAM_RX);
    assign serial_stream_tx_en = (s_r.pkt_fmt == radio_cfg_pkg::FMT_STREAM_TX);
    assign format_reserved     = !packet_mode && !serial_stream_rx_en && !serial_stream_tx_en;

    // Retention decode; reserved codes retain nothing
    logic [3:0] retain_code;
    assign retain_code = s_r.sleep_cfg[radio_cfg_pkg::RETAIN_LSB +: 4];
    assign retain_backup_ram    = (retain_code == radio_cfg_pkg::SLP_RAM)
                               || (retain_code == radio_cfg_pkg::SLP_RAM_XTAL)
                               || (retain_code == radio_cfg_pkg::SLP_RAM_RC);
    assign keep_crystal_running = (retain_code == radio_cfg_pkg::SLP_XTAL)
                               || (retain_code == radio_cfg_pkg::SLP_RAM_XTAL);
    assign retain_rc_clock      = (retain_code == radio_cfg_pkg::SLP_RAM_RC);

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence tx_cmd_taken(logic [7:0] dly, logic [7:0] ext);
        s_r.dly_st == radio_cfg_pkg::D_IDLE && transmit_command
            && s_r.tx_delay == dly && s_r.delay_ext == ext;
    endsequence

    sequence rx_cmd_taken(logic [7:0] dly, logic [7:0] ext);
        s_r.dly_st == radio_cfg_pkg::D_IDLE && receive_command && !transmit_command
            && s_r.rx_delay == dly && s_r.delay_ext == ext;
    endsequence

    sequence reg_write(logic [11:0] where);
        wr && idx == where;
    endsequence

    a_wb_answer: assert property (take |=> ack_o ##1 !ack_o)
        else $error("bus request not answered in one cycle");

    a_reset_values: assert property ($fell(reset) |-> s_r.tx_delay == 8'hc0
            && s_r.rx_delay == 8'hc0 && radio_cfg.preemphasis_en
            && radio_cfg.tx_frame_base == 8'h80 && s_r.delay_ext == 8'h00)
        else $error("configuration reset value wrong");

    a_tx_zero_delay: assert property (tx_cmd_taken(8'h00, 8'h00) |-> ##2 tx_state_enter)
        else $error("zero transmit delay did not fire after two cycles");

    a_tx_one_us: assert property (tx_cmd_taken(8'h01, 8'h00)
            |=> !tx_state_enter [*8] ##34 tx_state_enter)
        else $error("one microsecond transmit delay wrong");

    a_rx_ext_step: assert property (rx_cmd_taken(8'h00, 8'h01)
            |-> ##162 rx_search_start)
        else $error("delay extension step not four microseconds");

    a_rx_not_early: assert property (rx_cmd_taken(8'h01, 8'h00)
            |=> !rx_search_start [*8])
        else $error("receive start fired early");

    a_format_select: assert property (wr && idx == radio_cfg_pkg::IDX_PKT_FMT
            && dat_i[7:0] == 8'h02 |=> serial_stream_rx_en && !packet_mode && !format_reserved)
        else $error("receive streaming format not selected");

    a_chan_low_byte: assert property (reg_write(radio_cfg_pkg::IDX_CHAN_LO)
            |=> radio_cfg.channel_frequency_word[7:0] == $past(dat_i[7:0]))
        else $error("channel word low byte not written");

    a_div_staged: assert property (reg_write(radio_cfg_pkg::IDX_DIV_SEL)
            |=> s_r.div_active == $past(s_r.div_active))
        else $error("divider took effect before commit");

    a_div_commit: assert property (reg_write(radio_cfg_pkg::IDX_SLEEP_CFG)
            |=> s_r.div_active == $past(s_r.div_staged))
        else $error("divider not committed by sleep write");

    a_reload_commit: assert property (reg_write(radio_cfg_pkg::IDX_RELOAD_LO)
            |=> s_r.reload_active == {$past(s_r.reload_hi), $past(dat_i[7:0])})
        else $error("reload not committed from staged high byte");

    a_reload_hold: assert property (reg_write(radio_cfg_pkg::IDX_RELOAD_HI)
            |=> $stable(s_r.reload_active))
        else $error("reload changed on high byte write");

    a_wake_gated: assert property (wake_event |-> $past(s_r.sleep_cfg[0]))
        else $error("wake event while wake disabled");

    a_div_one_tick: assert property (slow_edge && s_r.div_active == 3'd0
            && s_r.sleep_cfg[0] && s_r.wake_cnt == 16'h0000 && !wr |=> wake_event)
        else $error("divide by one did not time out on edge");

    a_power_ro: assert property (wr && idx == radio_cfg_pkg::IDX_RX_POWER && !rssi_valid
            |=> $stable(s_r.rx_power))
        else $error("write altered power readback");

    a_power_capture: assert property (rssi_valid |=> s_r.rx_power == $past(rssi_in))
        else $error("power readback not captured");

    a_preemp_write: assert property (reg_write(radio_cfg_pkg::IDX_TX_SHAPE)
            |=> radio_cfg.preemphasis_en == $past(dat_i[0]))
        else $error("pre-emphasis enable not written");

    a_tx_base_write: assert property (reg_write(radio_cfg_pkg::IDX_TX_BASE)
            |=> radio_cfg.tx_frame_base == $past(dat_i[7:0]))
        else $error("transmit frame base not written");

    a_rx_base_write: assert property (reg_write(radio_cfg_pkg::IDX_RX_BASE)
            |=> radio_cfg.rx_frame_base == $past(dat_i[7:0]))
        else $error("receive frame base not written");

    a_chan_high_byte: assert property (reg_write(radio_cfg_pkg::IDX_CHAN_HI)
            |=> radio_cfg.channel_frequency_word[23:16] == $past(dat_i[7:0]))
        else $error("channel word high byte not written");

    a_quality_capture: assert property (sqi_valid |=> s_r.rx_quality == $past(sqi_in))
        else $error("quality readback not captured");

    a_quality_ro: assert property (wr && idx == radio_cfg_pkg::IDX_RX_QUAL && !sqi_valid
            |=> $stable(s_r.rx_quality))
        else $error("write altered quality readback");

    a_fire_pulse: assert property ((tx_state_enter || rx_search_start)
            |-> start_delay_busy ##1 !start_delay_busy)
        else $error("start pulse or busy span wrong");

endmodule

// [test/testbench.sv]
// Register bank bench: bus access, start delays, readback and wake timer
`timescale 1ns/1ps
module testbench;
    logic        clk = 0, reset = 1, cyc_i = 0, stb_i = 0, we_i = 0, tx_cmd = 0, rx_cmd = 0;
    logic        rssi_valid = 0, sqi_valid = 0, slow = 0, ack_o, tx_enter, rx_start, busy, wake;
    logic        pkt, s_rx, s_tx, f_res, r_ram, r_xtal, r_rc;
    logic [13:0] adr_i = 0;
    logic [3:0]  sel_i = 4'h1;
    logic [31:0] dat_i = 0, dat_o, rd;
    logic [7:0]  rssi_in = 0, sqi_in = 0;
    radio_cfg_pkg::radio_cfg_t cfg;
    int          error_cnt = 0, checked = 0, cycles = 0, wakes = 0, n;
    logic [7:0] n_fmt [4] = '{8'h00, 8'h02, 8'h03, 8'h01};
    logic [3:0] n_dec [4] = '{4'h8, 4'h4, 4'h2, 4'h1};
    logic [7:0] n_slp [4] = '{8'h08, 8'h20, 8'h28, 8'h58};
    logic [2:0] n_ret [4] = '{3'h4, 3'h2, 3'h6, 3'h5};
    always #12.5 clk = ~clk;
    radio_config_wake_timer_regs dut_u (.clk(clk), .reset(reset), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o), .dat_o(dat_o),
        .transmit_command(tx_cmd), .receive_command(rx_cmd), .rssi_valid(rssi_valid),
        .rssi_in(rssi_in), .sqi_valid(sqi_valid), .sqi_in(sqi_in), .tx_state_enter(tx_enter),
        .rx_search_start(rx_start), .start_delay_busy(busy), .radio_cfg(cfg),
        .packet_mode(pkt), .serial_stream_rx_en(s_rx), .serial_stream_tx_en(s_tx),
        .format_reserved(f_res), .slow_clock_pin(slow), .wake_event(wake),
        .retain_backup_ram(r_ram), .keep_crystal_running(r_xtal), .retain_rc_clock(r_rc));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("Compares %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [11:0] idx, input logic [7:0] d);
        @(posedge clk);
        {cyc_i, stb_i, we_i} <= {2'b11, w};
        adr_i <= {idx, 2'b00};
        dat_i <= {24'h0000_00, d};
        do @(posedge clk); while (ack_o !== 1'b1);
        rd = dat_o;
        {cyc_i, stb_i, we_i} <= 3'b000;
        @(posedge clk);
    endtask
    task automatic rchk(input logic [11:0] idx, input logic [7:0] exp);
        wb(0, idx, 8'h00);
        chk(rd, {24'h0000_00, exp});
    endtask
    task automatic cmd(input logic t, input int exp);
        @(posedge clk);
        if (t) tx_cmd <= 1; else rx_cmd <= 1;
        n = 0;
        do begin
            @(posedge clk);
            {tx_cmd, rx_cmd} <= 2'b00;
            n++;
        end while ((t ? tx_enter : rx_start) !== 1'b1 && n < 400);
        chk(n, exp);
        chk(busy, 32'h1);
        @(posedge clk);
        chk({busy, tx_enter, rx_start}, 32'h0);
    endtask
    task automatic pulses(input int k);
        repeat (k) begin
            repeat (6) @(posedge clk);
            slow <= 1;
            repeat (6) @(posedge clk);
            slow <= 0;
        end
        repeat (8) @(posedge clk);
    endtask
    always @(posedge clk) begin
        cycles++;
        if (wake === 1'b1) wakes++;
        if (cycles == 20000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clk);
        reset <= 0;
        rchk(12'h10a, 8'hc0);
        rchk(12'h109, 8'hc0);
        rchk(12'h10b, 8'h00);
        rchk(12'h13e, 8'h00);
        chk(cfg.channel_frequency_word, 32'h0003_a980);
        rchk(12'h306, 8'h01);
        rchk(12'h30c, 8'h00);
        rchk(12'h30d, 8'h00);
        rchk(12'h314, 8'h80);
        rchk(12'h315, 8'h00);
        rchk(12'h317, 8'h00);
        rchk(12'h316, 8'h00);
        rchk(12'h3ff, 8'h00);
        foreach (n_fmt[i]) begin
            wb(1, 12'h13e, n_fmt[i]);
            chk({pkt, s_rx, s_tx, f_res}, n_dec[i]);
            chk(cfg.packet_format_select, n_fmt[i]);
        end
        wb(1, 12'h300, 8'h12);
        wb(1, 12'h302, 8'h05);
        chk(cfg.channel_frequency_word, 32'h0005_a912);
        rchk(12'h302, 8'h05);
        wb(1, 12'h306, 8'h00);
        chk(cfg.preemphasis_en, 32'h0);
        wb(1, 12'h314, 8'h3c);
        chk(cfg.tx_frame_base, 32'h3c);
        wb(1, 12'h315, 8'hc4);
        chk(cfg.rx_frame_base, 32'hc4);
        wb(1, 12'h313, 8'hf7);
        rchk(12'h313, 8'h07);
        chk(cfg.program_page, 32'h7);
        @(posedge clk);
        {rssi_valid, rssi_in, sqi_valid, sqi_in} <= {1'b1, 8'hb5, 1'b1, 8'h5a};
        @(posedge clk);
        {rssi_valid, sqi_valid} <= 2'b00;
        wb(1, 12'h30c, 8'h11);
        wb(1, 12'h30d, 8'h22);
        rchk(12'h30c, 8'hb5);
        rchk(12'h30d, 8'h5a);
        rchk(12'h30c, 8'hb5);
        wb(1, 12'h10a, 8'h02);
        wb(1, 12'h10b, 8'h01);
        cmd(1, 243);
        wb(1, 12'h109, 8'h00);
        wb(1, 12'h10b, 8'h00);
        cmd(0, 3);
        foreach (n_slp[i]) begin
            wb(1, 12'h317, n_slp[i]);
            chk({r_ram, r_xtal, r_rc}, n_ret[i]);
        end
        wb(1, 12'h318, 8'h00);
        wb(1, 12'h319, 8'h00);
        wb(1, 12'h316, 8'h01);
        wb(1, 12'h317, 8'h01);
        rchk(12'h317, 8'h01);
        wakes = 0;
        pulses(16);
        chk(wakes, 32'h4);
        wb(1, 12'h318, 8'h01);
        rchk(12'h318, 8'h00);
        wb(1, 12'h316, 8'h00);
        wb(1, 12'h317, 8'h01);
        wakes = 0;
        pulses(3);
        chk(wakes, 32'h3);
        wb(1, 12'h319, 8'h02);
        rchk(12'h319, 8'h02);
        tally_and_finish();
    end
endmodule
